// ### logic/usb_host_rx_pkg.sv
// Package: constants and types for the host receive endpoint status block
package usb_host_rx_pkg;

	localparam logic [3:0] OFF_RX_CTRL = 4'h0;
	localparam logic [3:0] OFF_EP0_COUNT = 4'h4;
	localparam logic [3:0] OFF_RX_COUNT = 4'h8;
	localparam logic [3:0] OFF_EP0_SPEED = 4'hC;
	localparam logic [3:0] OFF_PROTOCOL = 4'h1;
	localparam logic [3:0] OFF_NAK_LIMIT = 4'h2;
	localparam logic [3:0] OFF_IRQ_STATUS = 4'h3;
	localparam logic [3:0] OFF_IRQ_MASK = 4'h5;

	localparam int BIT_TOG_WREN = 10;
	localparam int BIT_TOG = 9;
	localparam int BIT_TOG_CLR = 7;
	localparam int BIT_STALL = 6;
	localparam int BIT_REQ = 5;
	localparam int BIT_FLUSH = 4;
	localparam int BIT_DERR = 3;
	localparam int BIT_ERROR = 2;
	localparam int BIT_FULL = 1;
	localparam int BIT_RDY = 0;

	localparam int SPEED_LSB = 6;
	localparam int IRQ_STALL = 0;
	localparam int IRQ_ERROR = 1;
	localparam int IRQ_RDY = 2;
	localparam int IRQ_W = 3;

	localparam logic [1:0] RETRY_LIMIT = 2'h3;
	localparam logic [1:0] PROT_ISO = 2'h1;
	localparam logic [1:0] PROT_BULK = 2'h2;
	localparam logic [1:0] SPEED_ILLEGAL = 2'h0;
	localparam logic [15:0] ZERO16 = 16'h0000;

	typedef struct packed {
		logic [3:0] addr;
		logic [15:0] wdata;
		logic wr;
		logic rd;
	} reg_req_t;

	typedef struct packed {
		logic pkt_good;
		logic pkt_crc_err;
		logic stall;
		logic no_data;
		logic nak_timeout;
		logic no_room;
		logic [12:0] byte_count;
		logic toggle_next;
	} link_evt_t;

	typedef struct packed {
		logic tog_wren;
		logic tog;
		logic stall;
		logic req;
		logic derr;
		logic error;
		logic full;
		logic rdy;
		logic halted;
		logic [1:0] retries;
		logic [12:0] count;
		logic [1:0] speed;
		logic [1:0] prot;
		logic [7:0] nak_limit;
		logic [IRQ_W-1:0] irq_stat;
		logic [IRQ_W-1:0] irq_mask;
		logic [15:0] rdata;
		logic irq;
		logic in_token;
		logic flush_pulse;
	} state_t;

endpackage : usb_host_rx_pkg

// ### logic/usb_host_rx_endpoint_status.sv
// Module: host receive endpoint control, status, counts and interrupt
//
// The placing of the registers and the strobed register port were chosen for this implementation.
`timescale 1ns/1ps
// Function
// - Toggle bit reads current data toggle
// - Toggle write only while write enable high
// - Write enable clears after toggle written
// - Clear-toggle write forces toggle zero
// - STALL sets sticky flag and interrupt
// - Request starts IN; clears on ready
// - Flush discards packet, clears ready
// - Flush ignored unless packet ready set
// - ISO CRC error flag follows ready
// - Bulk NAK timeout halts, sets flag
// - Three empty attempts set error, interrupt
// - Error flag zero in isochronous mode
// - No-room flag when FIFO full
// - Packet received sets ready, interrupt
// - Seven-bit endpoint 0 byte count
// - Thirteen-bit receive packet byte count
// - Two-bit endpoint 0 target speed
module usb_host_rx_endpoint_status (
	input wire logic i_clock,
	input wire logic i_sys_rst,
	input usb_host_rx_pkg::reg_req_t i_req,
	input usb_host_rx_pkg::link_evt_t i_evt,
	output logic [15:0] o_rdata,
	output logic o_irq,
	output logic o_in_token,
	output logic o_flush,
	output logic o_toggle
);
	import usb_host_rx_pkg::*;

	state_t s_q;
	state_t s_d;
	logic wr_ctrl;
	logic [15:0] ctrl_view;
	logic [IRQ_W-1:0] ev;

	always_comb begin
		wr_ctrl = i_req.wr && (i_req.addr == OFF_RX_CTRL);
		ctrl_view = ZERO16;
		ctrl_view[BIT_TOG_WREN] = s_q.tog_wren;
		ctrl_view[BIT_TOG] = s_q.tog;
		ctrl_view[BIT_STALL] = s_q.stall;
		ctrl_view[BIT_REQ] = s_q.req;
		ctrl_view[BIT_DERR] = s_q.derr;
		ctrl_view[BIT_ERROR] = (s_q.prot == PROT_ISO) ? 1'b0 : s_q.error;
		ctrl_view[BIT_FULL] = s_q.full;
		ctrl_view[BIT_RDY] = s_q.rdy;
		ev = '0;
		s_d = s_q;
		s_d.in_token = 1'b0;
		s_d.flush_pulse = 1'b0;
		s_d.rdata = ZERO16;

		// Software writes to control, speed, protocol, NAK limit and interrupt mask registers
		if (wr_ctrl) begin
			if (!i_req.wdata[BIT_STALL]) begin
				s_d.stall = 1'b0;
			end
			if (!i_req.wdata[BIT_ERROR]) begin
				s_d.error = 1'b0;
			end
			if (!i_req.wdata[BIT_DERR]) begin
				s_d.derr = 1'b0;
				s_d.halted = 1'b0;
			end
			if (!i_req.wdata[BIT_RDY]) begin
				s_d.rdy = 1'b0;
				s_d.derr = (s_q.prot == PROT_ISO) ? 1'b0 : s_d.derr;
			end
			if (i_req.wdata[BIT_TOG_WREN]) begin
				s_d.tog_wren = 1'b1;
			end
			if (s_q.tog_wren && !i_req.wdata[BIT_TOG_WREN]) begin
				s_d.tog = i_req.wdata[BIT_TOG];
				s_d.tog_wren = 1'b0;
			end
			if (i_req.wdata[BIT_TOG_CLR]) begin
				s_d.tog = 1'b0;
			end
			if (i_req.wdata[BIT_REQ] && !s_q.halted) begin
				s_d.req = 1'b1;
				s_d.in_token = 1'b1;
				s_d.retries = 2'h0;
			end
			if (i_req.wdata[BIT_FLUSH] && s_q.rdy) begin
				s_d.rdy = 1'b0;
				s_d.count = 13'h0000;
				s_d.flush_pulse = 1'b1;
				s_d.derr = (s_q.prot == PROT_ISO) ? 1'b0 : s_d.derr;
			end
		end else if (i_req.wr && i_req.addr == OFF_EP0_SPEED) begin
			s_d.speed = i_req.wdata[SPEED_LSB +: 2];
		end else if (i_req.wr && i_req.addr == OFF_PROTOCOL) begin
			s_d.prot = i_req.wdata[1:0];
		end else if (i_req.wr && i_req.addr == OFF_NAK_LIMIT) begin
			s_d.nak_limit = i_req.wdata[7:0];
		end else if (i_req.wr && i_req.addr == OFF_IRQ_MASK) begin
			s_d.irq_mask = i_req.wdata[IRQ_W-1:0];
		end

		// Link events; set wins over software clear
		s_d.full = i_evt.no_room;
		if (i_evt.stall && s_q.req) begin
			s_d.stall = 1'b1;
			s_d.req = 1'b0;
			ev[IRQ_STALL] = 1'b1;
		end
		if (i_evt.pkt_good && s_q.req) begin
			s_d.rdy = 1'b1;
			s_d.req = 1'b0;
			s_d.count = i_evt.byte_count;
			s_d.tog = i_evt.toggle_next;
			ev[IRQ_RDY] = 1'b1;
			if (s_q.prot == PROT_ISO && i_evt.pkt_crc_err) begin
				s_d.derr = 1'b1;
			end
		end
		if (i_evt.no_data && s_q.req && s_q.prot != PROT_ISO) begin
			if (s_q.retries == RETRY_LIMIT - 2'h1) begin
				s_d.error = 1'b1;
				s_d.req = 1'b0;
				ev[IRQ_ERROR] = 1'b1;
			end else begin
				s_d.retries = s_q.retries + 2'h1;
				s_d.in_token = 1'b1;
			end
		end
		if (i_evt.nak_timeout && s_q.req && s_q.prot == PROT_BULK) begin
			s_d.derr = 1'b1;
			s_d.halted = 1'b1;
			s_d.req = 1'b0;
		end

		// Sticky interrupt status, write one to clear
		if (i_req.wr && i_req.addr == OFF_IRQ_STATUS) begin
			s_d.irq_stat = s_q.irq_stat & ~i_req.wdata[IRQ_W-1:0];
		end
		s_d.irq_stat = s_d.irq_stat | ev;
		s_d.irq = |(s_d.irq_stat & s_d.irq_mask);

		// Read data one cycle later
		if (i_req.rd) begin
			if (i_req.addr == OFF_RX_CTRL) begin
				s_d.rdata = ctrl_view;
			end else if (i_req.addr == OFF_EP0_COUNT) begin
				s_d.rdata = {9'h000, s_q.count[6:0]};
			end else if (i_req.addr == OFF_RX_COUNT) begin
				s_d.rdata = {3'h0, s_q.count};
			end else if (i_req.addr == OFF_EP0_SPEED) begin
				s_d.rdata = {8'h00, s_q.speed, 6'h00};
			end else if (i_req.addr == OFF_PROTOCOL) begin
				s_d.rdata = {14'h0000, s_q.prot};
			end else if (i_req.addr == OFF_NAK_LIMIT) begin
				s_d.rdata = {8'h00, s_q.nak_limit};
			end else if (i_req.addr == OFF_IRQ_STATUS) begin
				s_d.rdata = {13'h0000, s_q.irq_stat};
			end else if (i_req.addr == OFF_IRQ_MASK) begin
				s_d.rdata = {13'h0000, s_q.irq_mask};
			end else begin
				s_d.rdata = ZERO16;
			end
		end
	end

	always_ff @(posedge i_clock) begin
		if (i_sys_rst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign o_rdata = s_q.rdata;
	assign o_irq = s_q.irq;
	assign o_in_token = s_q.in_token;
	assign o_flush = s_q.flush_pulse;
	assign o_toggle = s_q.tog;

	sequence seq_req_write;
		wr_ctrl && i_req.wdata[BIT_REQ] && !s_q.halted;
	endsequence

	AST_TOG_READ: assert property (@(posedge i_clock) disable iff (i_sys_rst)
		i_req.rd && i_req.addr == OFF_RX_CTRL |=> o_rdata[BIT_TOG] == $past(s_q.tog))
		else $error("toggle read mismatch");
	AST_TOG_GUARD: assert property (@(posedge i_clock) disable iff (i_sys_rst)
		wr_ctrl && !s_q.tog_wren && !i_req.wdata[BIT_TOG_CLR] && !(i_evt.pkt_good && s_q.req)
		|=> s_q.tog == $past(s_q.tog))
		else $error("toggle changed without enable");
	AST_WREN_AUTO: assert property (@(posedge i_clock) disable iff (i_sys_rst)
		wr_ctrl && s_q.tog_wren && !i_req.wdata[BIT_TOG_WREN] |=> !s_q.tog_wren)
		else $error("write enable not cleared");
	AST_TOG_CLEAR: assert property (@(posedge i_clock) disable iff (i_sys_rst)
		wr_ctrl && i_req.wdata[BIT_TOG_CLR] |=> !o_toggle)
		else $error("toggle not cleared");
	AST_STALL_SET: assert property (@(posedge i_clock) disable iff (i_sys_rst)
		i_evt.stall && s_q.req |=> s_q.stall && s_q.irq_stat[IRQ_STALL])
		else $error("stall not flagged");
	AST_REQ_TOKEN: assert property (@(posedge i_clock) disable iff (i_sys_rst)
		seq_req_write |=> o_in_token && s_q.req)
		else $error("IN request not started");
	AST_FLUSH: assert property (@(posedge i_clock) disable iff (i_sys_rst)
		wr_ctrl && i_req.wdata[BIT_FLUSH] && s_q.rdy && !i_evt.pkt_good |=> !s_q.rdy && o_flush)
		else $error("flush did not clear ready");
	AST_FLUSH_IGN: assert property (@(posedge i_clock) disable iff (i_sys_rst)
		!s_q.rdy |=> !o_flush)
		else $error("flush acted without ready");
	AST_ISO_ERR0: assert property (@(posedge i_clock) disable iff (i_sys_rst)
		i_req.rd && i_req.addr == OFF_RX_CTRL && s_q.prot == PROT_ISO |=> !o_rdata[BIT_ERROR])
		else $error("error bit visible in iso mode");
	AST_RDY_IRQ: assert property (@(posedge i_clock) disable iff (i_sys_rst)
		i_evt.pkt_good && s_q.req && s_q.irq_mask[IRQ_RDY] |=> s_q.rdy ##1 o_irq)
		else $error("ready interrupt missing");
	AST_FULL: assert property (@(posedge i_clock) disable iff (i_sys_rst)
		i_evt.no_room |=> s_q.full)
		else $error("no-room flag missing");

	sequence seq_iso_bad_pkt;
		i_evt.pkt_good && i_evt.pkt_crc_err && s_q.req && s_q.prot == PROT_ISO;
	endsequence

	sequence seq_last_retry;
		i_evt.no_data && s_q.req && s_q.prot != PROT_ISO && s_q.retries == RETRY_LIMIT - 2'h1;
	endsequence

	AST_ISO_DERR: assert property (@(posedge i_clock) disable iff (i_sys_rst)
		seq_iso_bad_pkt |=> s_q.derr && s_q.rdy)
		else $error("iso data error flag missing");
	AST_NAK_HALT: assert property (@(posedge i_clock) disable iff (i_sys_rst)
		i_evt.nak_timeout && s_q.req && s_q.prot == PROT_BULK
		|=> s_q.halted && s_q.derr && !s_q.req)
		else $error("nak timeout did not halt");
	AST_RETRY_ERR: assert property (@(posedge i_clock) disable iff (i_sys_rst)
		seq_last_retry |=> s_q.error && s_q.irq_stat[IRQ_ERROR] && !s_q.req)
		else $error("no-response error missing");
	AST_IRQ_LEVEL: assert property (@(posedge i_clock) disable iff (i_sys_rst)
		o_irq == |(s_q.irq_stat & s_q.irq_mask))
		else $error("interrupt level mismatch");

endmodule : usb_host_rx_endpoint_status

// ### sim/usb_target_model.sv
// Target device model answering each IN token after a set delay
`timescale 1ns/1ps
module usb_target_model (
	input wire logic i_clock,
	input wire logic i_tok,
	input wire logic [2:0] i_mode,
	input wire logic [3:0] i_delay,
	input wire logic [12:0] i_count,
	input wire logic i_tog,
	input wire logic i_full,
	output usb_host_rx_pkg::link_evt_t o_evt
);
	import usb_host_rx_pkg::*;
	int wait_q = -1;
	link_evt_t e;
	always_comb begin
		e = '0;
		e.no_room = i_full;
		e.byte_count = ~i_count;
		e.toggle_next = ~i_tog;
		if (wait_q == 0) begin
			e.byte_count = i_count;
			case (i_mode)
				3'd0: e.pkt_good = 1'b1;
				3'd1: begin
					e.pkt_good = 1'b1;
					e.pkt_crc_err = 1'b1;
				end
				3'd2: e.stall = 1'b1;
				3'd3: e.no_data = 1'b1;
				default: e.nak_timeout = 1'b1;
			endcase
		end
	end
	assign o_evt = e;
	always @(posedge i_clock) begin
		if (i_tok) begin
			wait_q <= int'(i_delay);
		end else if (wait_q >= 0) begin
			wait_q <= wait_q - 1;
		end
	end
endmodule : usb_target_model

// ### sim/tb.sv
// Bench for the host receive endpoint status block
`timescale 1ns/1ps
module tb;
	import usb_host_rx_pkg::*;
	logic i_clock = 0;
	logic i_sys_rst = 1;
	logic full = 0;
	logic [3:0] dly = 4'h3;
	logic [2:0] mode = 0;
	reg_req_t req = '0;
	link_evt_t evt;
	logic [15:0] o_rdata;
	logic o_irq, o_in_token, o_flush, o_toggle;
	int n_fail = 0, total_checks = 0, n_tok = 0, n_fl = 0, cyc = 0, f;
	usb_host_rx_endpoint_status usb_host_rx_endpoint_status_i (.i_clock(i_clock),
		.i_sys_rst(i_sys_rst), .i_req(req), .i_evt(evt), .o_rdata(o_rdata), .o_irq(o_irq),
		.o_in_token(o_in_token), .o_flush(o_flush), .o_toggle(o_toggle));
	usb_target_model usb_target_model_i (.i_clock(i_clock), .i_tok(o_in_token), .i_mode(mode),
		.i_delay(dly), .i_count(13'h01A5), .i_tog(o_toggle), .i_full(full), .o_evt(evt));
	initial begin
		forever #12.5 i_clock = ~i_clock;
	end
	always @(posedge i_clock) begin
		cyc <= cyc + 1;
		n_tok <= n_tok + int'(o_in_token);
		n_fl <= n_fl + int'(o_flush);
		if (cyc == 5000) begin
			n_fail++;
			test_done();
		end
	end
	task automatic test_done();
		if (n_fail == 0 && total_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : test_done
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected %0t got %h want %h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [3:0] a, input logic [15:0] v);
		req <= '{a, v, 1'b1, 1'b0};
		@(posedge i_clock);
		req.wr <= 1'b0;
		@(posedge i_clock);
	endtask : wr
	task automatic rd(input logic [3:0] a, input logic [15:0] e, input logic [15:0] m = 16'hFFFF);
		req <= '{a, 16'h0000, 1'b0, 1'b1};
		@(posedge i_clock);
		req.rd <= 1'b0;
		@(negedge i_clock);
		chk(o_rdata & m, e);
		@(posedge i_clock);
	endtask : rd
	task automatic pin(ref logic s, input logic e);
		@(negedge i_clock);
		chk({15'h0000, s}, {15'h0000, e});
		@(posedge i_clock);
	endtask : pin
	task automatic go(input logic [2:0] m, input logic [15:0] c);
		mode <= m;
		wr(OFF_RX_CTRL, c);
		repeat (30) @(posedge i_clock);
	endtask : go
	task automatic t_regs();
		rd(OFF_RX_CTRL, ZERO16);
		rd(OFF_EP0_COUNT, ZERO16);
		rd(OFF_RX_COUNT, ZERO16);
		rd(OFF_IRQ_STATUS, ZERO16);
		pin(o_irq, 1'b0);
		for (int s = 0; s < 4; s++) begin
			wr(OFF_EP0_SPEED, {8'hFF, 2'(s), 6'h3F});
			rd(OFF_EP0_SPEED, {8'h00, 2'(s), 6'h00});
		end
		wr(OFF_NAK_LIMIT, 16'hFFAB);
		rd(OFF_NAK_LIMIT, 16'h00AB);
		wr(4'h7, 16'hFFFF);
		rd(4'h7, ZERO16);
	endtask : t_regs
	task automatic t_toggle();
		wr(OFF_RX_CTRL, 16'h0200);
		rd(OFF_RX_CTRL, ZERO16);
		wr(OFF_RX_CTRL, 16'h0400);
		wr(OFF_RX_CTRL, 16'h0200);
		rd(OFF_RX_CTRL, 16'h0200);
		pin(o_toggle, 1'b1);
		wr(OFF_RX_CTRL, 16'h0080);
		rd(OFF_RX_CTRL, ZERO16);
	endtask : t_toggle
	task automatic t_rx();
		wr(OFF_IRQ_MASK, 16'h0007);
		wr(OFF_PROTOCOL, {14'h0, PROT_BULK});
		rd(OFF_IRQ_MASK, 16'h0007);
		rd(OFF_PROTOCOL, {14'h0, PROT_BULK});
		go(3'd0, 16'h0020);
		rd(OFF_RX_CTRL, 16'h0201);
		rd(OFF_RX_COUNT, 16'h01A5);
		rd(OFF_EP0_COUNT, 16'h0025);
		rd(OFF_IRQ_STATUS, 16'h0004);
		pin(o_irq, 1'b1);
		wr(OFF_IRQ_STATUS, 16'h0004);
		pin(o_irq, 1'b0);
		f = n_fl;
		wr(OFF_RX_CTRL, 16'h0011);
		rd(OFF_RX_CTRL, 16'h0200);
		wr(OFF_RX_CTRL, 16'h0010);
		chk(16'(n_fl - f), 16'h0001);
	endtask : t_rx
	task automatic t_events();
		go(3'd2, 16'h0020);
		rd(OFF_RX_CTRL, 16'h0040, 16'h0040);
		rd(OFF_IRQ_STATUS, 16'h0001, 16'h0001);
		wr(OFF_IRQ_STATUS, 16'h0007);
		f = n_tok;
		go(3'd3, 16'h0020);
		chk(16'(n_tok - f), 16'h0003);
		rd(OFF_RX_CTRL, 16'h0004, 16'h0004);
		rd(OFF_IRQ_STATUS, 16'h0002, 16'h0002);
		wr(OFF_PROTOCOL, {14'h0, PROT_ISO});
		rd(OFF_RX_CTRL, ZERO16, 16'h0004);
		go(3'd1, 16'h0020);
		rd(OFF_RX_CTRL, 16'h0009, 16'h0009);
		wr(OFF_RX_CTRL, 16'h0008);
		rd(OFF_RX_CTRL, ZERO16, 16'h0009);
	endtask : t_events
	task automatic t_nak();
		wr(OFF_PROTOCOL, {14'h0, PROT_BULK});
		dly <= 4'hF;
		go(3'd4, 16'h0020);
		rd(OFF_RX_CTRL, 16'h0008, 16'h0008);
		f = n_tok;
		go(3'd0, 16'h0028);
		chk(16'(n_tok - f), ZERO16);
		wr(OFF_RX_CTRL, ZERO16);
		go(3'd0, 16'h0020);
		rd(OFF_RX_CTRL, 16'h0001, 16'h0021);
		full <= 1'b1;
		repeat (2) @(posedge i_clock);
		rd(OFF_RX_CTRL, 16'h0002, 16'h0002);
		full <= 1'b0;
		repeat (2) @(posedge i_clock);
		rd(OFF_RX_CTRL, ZERO16, 16'h0002);
	endtask : t_nak
	initial begin
		repeat (16) @(posedge i_clock);
		i_sys_rst <= 1'b0;
		@(posedge i_clock);
		t_regs();
		t_toggle();
		t_rx();
		t_events();
		t_nak();
		test_done();
	end
endmodule : tb
